/* verilog/sbcp_pkg.sv */
// constants, enums and maps shared by both ends of the config port link
// assumes the host runs on a 20 MHz clock and the device on the bus clock
`default_nettype none

package sbcp_pkg;

	// slave addressing: the write byte, the read byte and the 7-bit address
	localparam logic [7:0] ADDR_WR = 8'hdc;
	localparam logic [7:0] ADDR_RD = 8'hdd;
	localparam logic [6:0] DEV_ADDR7 = 7'h6e;

	// configuration byte array held by the device
	localparam int NUM_BYTES = 8;
	localparam logic [2:0] MODE_BYTE = 3'h0;
	localparam logic [2:0] COUNT_BYTE = 3'h6;
	localparam logic [7:0] MODE_RESET = 8'h07;
	localparam logic [7:0] COUNT_RESET = 8'h07;
	localparam logic [7:0] OTHER_RESET = 8'h00;

	// field positions inside the mode select byte
	localparam int PD_STYLE_BIT = 7;
	localparam int HALT_STYLE_BIT = 6;
	localparam int PD_LEVEL_BIT = 5;
	localparam int BW_BIT = 2;
	localparam int ZDB_BIT = 1;
	localparam int HALVE_BIT = 0;

	// bus clock timing, derived from the host clock
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_CYCLES = SCL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int QUARTER_CYCLES = SCL_CYCLES / 4;
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYCLES - 1);

	// host command port map
	localparam logic [3:0] HOST_INDEX = 4'h0;
	localparam logic [3:0] HOST_COUNT = 4'h1;
	localparam logic [3:0] HOST_CMD = 4'h2;
	localparam logic [3:0] HOST_STATUS = 4'h3;
	localparam logic [3:0] HOST_RXCNT = 4'h4;
	localparam logic [3:0] HOST_BUF = 4'h8;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam logic [7:0] HOST_RESET = 8'h00;

	typedef enum logic [5:0] {
		D_IDLE = 6'h01,
		D_ADDR = 6'h02,
		D_INDEX = 6'h04,
		D_COUNT = 6'h08,
		D_WDATA = 6'h10,
		D_RDATA = 6'h20
	} sbcp_dev_phase_e;

	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BYTE = 4'h4,
		H_STOP = 4'h8
	} sbcp_host_state_e;

endpackage : sbcp_pkg

`default_nettype wire

/* verilog/sbcp_link_if.sv */
// two-wire link between the host and the configuration port
// assumes the host alone drives the bus clock; data is open drain
`timescale 1ns/1ps
`default_nettype none

interface sbcp_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// wired-and data line with a pull-up when nobody drives
	assign sda = (~host_sda_oe | host_sda_o) & (~dev_sda_oe | dev_sda_o);

	modport host (output scl, output host_sda_o, output host_sda_oe,
		input sda);
	modport device (input scl, input sda, output dev_sda_o,
		output dev_sda_oe);
endinterface : sbcp_link_if

`default_nettype wire

/* verilog/sbcp_cond_cell.sv */
// catches a data edge while the bus clock is high (start or stop)
// assumes clr_in is held until the owner has seen the flag
`timescale 1ns/1ps
`default_nettype none

module sbcp_cond_cell #(
	parameter logic FALL = 1'b1
) (
	input wire logic sda_in,
	input wire logic scl_in,
	input wire logic clr_in,
	output logic seen_out
);
	typedef struct packed {
		logic seen;
	} sbcp_cell_s;

	sbcp_cell_s cur;
	sbcp_cell_s next_cur;
	logic edge_clk;

	// the data line itself is the clock: no bus clock edge marks these
	assign edge_clk = FALL ? ~sda_in : sda_in;

	always_comb
	begin
		next_cur = cur;
		if (scl_in)
			next_cur.seen = 1'b1;
	end

	always_ff @(posedge edge_clk or posedge clr_in)
	begin
		if (clr_in)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign seen_out = cur.seen;
endmodule : sbcp_cond_cell

`default_nettype wire

/* verilog/sbcp_device.sv */
// configuration port slave: indexed block write and block read of the
// configuration byte array, and the mode select byte decoded to outputs
// assumes the bus clock comes from the host and reset_in is held over
// at least one falling bus clock edge
//
// Function
// R1: acknowledge write address byte DC
// R2: host sends index N, device acknowledges
// R3: host sends count X, device acknowledges
// R4: store X bytes from N, ack each
// R5: host ends block write with stop
// R6: block read uses repeated start after index
// R7: acknowledge read address byte DD
// R8: send count first, then bytes N onward
// R9: host acknowledges every byte but last
// R10: host ends read with not-ack, stop
// R11: mode bit 7 power-down drive, reset 0
// R12: mode bit 6 clock-halt drive, reset 0
// R13: mode bit 5 power-down pin level, reset 0
// R14: mode bit 2 loop bandwidth, reset 1
// R15: mode bit 1 zero-delay operation, reset 1
// R16: mode bit 0 input halving, reset 1
// R17: byte 6 holds read count, reset 7
// R18: 7-bit address match, ignore others
// R19: index advances after each data byte
`timescale 1ns/1ps
`default_nettype none

module sbcp_device (
	sbcp_link_if.device link,
	input wire logic reset_in,
	output logic powerdown_output_style_out,
	output logic clock_halt_output_style_out,
	output logic powerdown_pin_level_select_out,
	output logic loop_bandwidth_select_out,
	output logic zero_delay_operation_out,
	output logic input_halving_select_out,
	output logic [7:0] read_count_out
);
	typedef struct packed {
		sbcp_pkg::sbcp_dev_phase_e phase;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic [7:0] index;
		logic [7:0] remain;
		logic first;
		logic sda_oe;
		logic cond_clr;
		logic [sbcp_pkg::NUM_BYTES-1:0][7:0] regs;
	} sbcp_dev_s;

	sbcp_dev_s cur;
	sbcp_dev_s next_cur;
	logic start_seen;
	logic stop_seen;
	logic cell_clr;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;

	////////////////////////////////////////////////////////////////////
	// start and stop catchers

	// cleared by reset or once the bus clock side has taken the start
	assign cell_clr = reset_in | cur.cond_clr;

	sbcp_cond_cell #(
		.FALL(1'b1)
	) u_start (
		.sda_in(link.sda),
		.scl_in(link.scl),
		.clr_in(cell_clr),
		.seen_out(start_seen)
	);

	sbcp_cond_cell #(
		.FALL(1'b0)
	) u_stop (
		.sda_in(link.sda),
		.scl_in(link.scl),
		.clr_in(cell_clr),
		.seen_out(stop_seen)
	);

	////////////////////////////////////////////////////////////////////
	// byte engine, one step per falling bus clock edge

	// data is stable while the clock is high, so the falling edge both
	// samples a bit and is the safe moment to change our own drive
	always_comb
	begin
		next_cur = cur;
		next_cur.cond_clr = 1'b0;
		rx_byte = {cur.shift[6:0], link.sda};
		tx_byte = sbcp_pkg::OTHER_RESET;
		if (cur.index < 8'(sbcp_pkg::NUM_BYTES))
			tx_byte = cur.regs[cur.index[2:0]];
		if (reset_in)
		begin
			next_cur = '0;
			next_cur.phase = sbcp_pkg::D_IDLE;
			// mode byte powers up driven, low level, low bw, zdb, 1x
			next_cur.regs[sbcp_pkg::MODE_BYTE] = sbcp_pkg::MODE_RESET; // [R11] [R12] [R13] [R14] [R15] [R16]
			next_cur.regs[sbcp_pkg::COUNT_BYTE] = sbcp_pkg::COUNT_RESET; // [R17]
		end
		else if (start_seen)
		begin
			// a start, first or repeated, always reopens address phase;
			// the index survives so a read continues from it
			next_cur.phase = sbcp_pkg::D_ADDR;
			next_cur.bitn = 4'h0;
			next_cur.sda_oe = 1'b0;
			next_cur.cond_clr = 1'b1;
		end
		else if (cur.phase == sbcp_pkg::D_RDATA)
		begin
			if (cur.bitn == 4'h8)
			begin
				if (cur.first || !link.sda)
				begin
					// count byte leads, then bytes from the index
					if (cur.first)
						next_cur.shift = cur.regs[sbcp_pkg::COUNT_BYTE]; // [R8] [R17]
					else
					begin
						next_cur.shift = tx_byte; // [R8]
						next_cur.index = cur.index + 8'h01; // [R19]
					end
					next_cur.sda_oe = cur.first ?
						~cur.regs[sbcp_pkg::COUNT_BYTE][7] : ~tx_byte[7];
					next_cur.first = 1'b0;
					next_cur.bitn = 4'h0;
				end
				else
				begin
					// not-ack from the host ends the read
					next_cur.phase = sbcp_pkg::D_IDLE; // [R10]
					next_cur.sda_oe = 1'b0;
				end
			end
			else if (cur.bitn == 4'h7)
			begin
				// let go so the host can answer
				next_cur.sda_oe = 1'b0; // [R9]
				next_cur.bitn = 4'h8;
			end
			else
			begin
				next_cur.shift = {cur.shift[6:0], 1'b0};
				next_cur.sda_oe = ~cur.shift[6];
				next_cur.bitn = cur.bitn + 4'h1;
			end
		end
		else if (cur.phase != sbcp_pkg::D_IDLE)
		begin
			if (cur.bitn == 4'h8)
			begin
				// acknowledge slot over
				next_cur.sda_oe = 1'b0;
				next_cur.bitn = 4'h0;
			end
			else
			begin
				next_cur.shift = rx_byte;
				next_cur.bitn = cur.bitn + 4'h1;
				if (cur.bitn == 4'h7)
				begin
					next_cur.bitn = 4'h8;
					unique case (cur.phase)
						sbcp_pkg::D_ADDR:
						begin
							// wrong address: stay silent until next start
							if (rx_byte[7:1] == sbcp_pkg::DEV_ADDR7) // [R18]
							begin
								next_cur.sda_oe = 1'b1; // [R1] [R7]
								next_cur.first = 1'b1;
								next_cur.phase = rx_byte[0] ?
									sbcp_pkg::D_RDATA : sbcp_pkg::D_INDEX;
							end
							else
								next_cur.phase = sbcp_pkg::D_IDLE;
						end
						sbcp_pkg::D_INDEX:
						begin
							next_cur.index = rx_byte; // [R2]
							next_cur.sda_oe = 1'b1; // [R2]
							next_cur.phase = sbcp_pkg::D_COUNT;
						end
						sbcp_pkg::D_COUNT:
						begin
							next_cur.remain = rx_byte; // [R3]
							next_cur.sda_oe = 1'b1; // [R3]
							next_cur.phase = sbcp_pkg::D_WDATA;
						end
						sbcp_pkg::D_WDATA:
						begin
							// bytes past the announced count are refused
							if (cur.remain != 8'h00)
							begin
								if (cur.index < 8'(sbcp_pkg::NUM_BYTES))
									next_cur.regs[cur.index[2:0]] = rx_byte; // [R4]
								next_cur.index = cur.index + 8'h01; // [R19]
								next_cur.remain = cur.remain - 8'h01;
								next_cur.sda_oe = 1'b1; // [R4]
							end
							else
								next_cur.phase = sbcp_pkg::D_IDLE;
						end
						sbcp_pkg::D_IDLE,
						sbcp_pkg::D_RDATA:
						begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(negedge link.scl)
	begin
		cur <= next_cur;
	end

	////////////////////////////////////////////////////////////////////
	// link drive and decoded mode outputs

	// a stop seen while high drops our drive at once: no clock edge follows
	assign link.dev_sda_oe = cur.sda_oe & ~stop_seen;
	assign link.dev_sda_o = 1'b0;

	assign powerdown_output_style_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::PD_STYLE_BIT]; // [R11]
	assign clock_halt_output_style_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::HALT_STYLE_BIT]; // [R12]
	assign powerdown_pin_level_select_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::PD_LEVEL_BIT]; // [R13]
	assign loop_bandwidth_select_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::BW_BIT]; // [R14]
	assign zero_delay_operation_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::ZDB_BIT]; // [R15]
	assign input_halving_select_out =
		cur.regs[sbcp_pkg::MODE_BYTE][sbcp_pkg::HALVE_BIT]; // [R16]
	assign read_count_out = cur.regs[sbcp_pkg::COUNT_BYTE]; // [R17]
endmodule : sbcp_device

`default_nettype wire

/* verilog/sbcp_host.sv */
// bus controller: runs indexed block writes and block reads on command
// assumes software uses the plain port, one strobe per cycle
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sbcp_host (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic busy_out,
	sbcp_link_if.host link
);
	typedef struct packed {
		sbcp_pkg::sbcp_host_state_e st;
		logic [1:0] q;
		logic [7:0] div;
		logic [3:0] bitn;
		logic [7:0] k;
		logic [7:0] shift;
		logic rd;
		logic err;
		logic [7:0] index;
		logic [7:0] count;
		logic [7:0] rxcnt;
		logic [7:0][7:0] buff;
		logic scl;
		logic oe;
		logic [7:0] rdata;
		logic s1;
		logic s2;
	} sbcp_host_s;

	sbcp_host_s cur;
	sbcp_host_s next_cur;
	logic tick;
	logic rx;
	logic last;

	// byte sent in step k of the current transfer
	function automatic logic [7:0] step_byte(input sbcp_host_s s,
		input logic [7:0] k);
		logic [7:0] b;
		b = s.buff[3'(k - 8'h03)];
		if (k == 8'h00)
			b = sbcp_pkg::ADDR_WR;
		else if (k == 8'h01)
			b = s.index;
		else if (k == 8'h02)
			b = s.rd ? sbcp_pkg::ADDR_RD : s.count;
		return b;
	endfunction : step_byte

	////////////////////////////////////////////////////////////////////
	// command port, divider and bit sequencer

	always_comb
	begin
		next_cur = cur;
		// two flops before the data line is looked at
		next_cur.s1 = link.sda;
		next_cur.s2 = cur.s1;
		next_cur.rdata = sbcp_pkg::HOST_RESET;
		tick = (cur.div == sbcp_pkg::QUARTER_LAST);
		next_cur.div = tick ? 8'h00 : cur.div + 8'h01;
		rx = cur.rd && (cur.k >= 8'h03);
		last = cur.rd ? (cur.k == cur.count + 8'h03)
			: (cur.k == cur.count + 8'h02);
		if (rd_in)
		begin
			if (addr_in[3])
				next_cur.rdata = cur.buff[addr_in[2:0]];
			else if (addr_in == sbcp_pkg::HOST_INDEX)
				next_cur.rdata = cur.index;
			else if (addr_in == sbcp_pkg::HOST_COUNT)
				next_cur.rdata = cur.count;
			else if (addr_in == sbcp_pkg::HOST_STATUS)
				next_cur.rdata = {6'h00, cur.err,
					cur.st != sbcp_pkg::H_IDLE};
			else if (addr_in == sbcp_pkg::HOST_RXCNT)
				next_cur.rdata = cur.rxcnt;
		end
		if (wr_in)
		begin
			if (addr_in[3])
				next_cur.buff[addr_in[2:0]] = wdata_in;
			else if (addr_in == sbcp_pkg::HOST_INDEX)
				next_cur.index = wdata_in;
			else if (addr_in == sbcp_pkg::HOST_COUNT)
				next_cur.count = wdata_in;
			else if (addr_in == sbcp_pkg::HOST_CMD
				&& cur.st == sbcp_pkg::H_IDLE
				&& (wdata_in[sbcp_pkg::CMD_WRITE_BIT]
				|| wdata_in[sbcp_pkg::CMD_READ_BIT]))
			begin
				// commands while busy are dropped
				next_cur.st = sbcp_pkg::H_START;
				next_cur.rd = wdata_in[sbcp_pkg::CMD_READ_BIT];
				next_cur.err = 1'b0;
				next_cur.k = 8'h00;
				next_cur.q = 2'h0;
				next_cur.div = 8'h00;
			end
		end
		if (tick && cur.st != sbcp_pkg::H_IDLE)
		begin
			next_cur.q = cur.q + 2'h1;
			unique case (cur.st)
				sbcp_pkg::H_START:
				begin
					// data falls while the clock is high
					if (cur.q == 2'h0)
						next_cur.scl = 1'b1;
					if (cur.q == 2'h1)
						next_cur.oe = 1'b1;
					if (cur.q == 2'h2)
						next_cur.scl = 1'b0;
					if (cur.q == 2'h3)
					begin
						next_cur.st = sbcp_pkg::H_BYTE;
						next_cur.bitn = 4'h0;
						next_cur.shift = step_byte(cur, cur.k);
					end
				end
				sbcp_pkg::H_BYTE:
				begin
					// data moves mid-low, never on a clock edge
					if (cur.q == 2'h0)
						next_cur.oe = (cur.bitn == 4'h8) ? (rx && !last) // [R9] [R10]
							: (!rx && !cur.shift[7]);
					if (cur.q == 2'h1)
						next_cur.scl = 1'b1;
					if (cur.q == 2'h3)
					begin
						next_cur.scl = 1'b0;
						next_cur.bitn = cur.bitn + 4'h1;
						if (cur.bitn != 4'h8)
							next_cur.shift = {cur.shift[6:0], cur.s2};
						else
						begin
							next_cur.bitn = 4'h0;
							if (rx && cur.k == 8'h03)
								next_cur.rxcnt = cur.shift;
							else if (rx)
								next_cur.buff[3'(cur.k - 8'h04)] = cur.shift;
							if ((!rx && cur.s2) || last)
							begin
								next_cur.err = !rx && cur.s2;
								next_cur.st = sbcp_pkg::H_STOP; // [R5] [R10]
							end
							else if (cur.rd && cur.k == 8'h01)
							begin
								next_cur.st = sbcp_pkg::H_START; // [R6]
								next_cur.k = 8'h02;
							end
							else
							begin
								next_cur.k = cur.k + 8'h01;
								next_cur.shift = step_byte(cur, cur.k + 8'h01);
							end
						end
					end
				end
				sbcp_pkg::H_STOP:
				begin
					// data rises while the clock is high
					if (cur.q == 2'h0)
						next_cur.oe = 1'b1;
					if (cur.q == 2'h1)
						next_cur.scl = 1'b1;
					if (cur.q == 2'h2)
						next_cur.oe = 1'b0;
					if (cur.q == 2'h3)
						next_cur.st = sbcp_pkg::H_IDLE;
				end
				sbcp_pkg::H_IDLE:
				begin
				end
			endcase
		end
		else if (tick)
			next_cur.scl = 1'b1;
		if (reset_in)
		begin
			// clock keeps toggling so the device reset can take; the
			// if form lands an unset divider on a known count at power-up
			next_cur = '0;
			next_cur.st = sbcp_pkg::H_IDLE;
			if (cur.div < sbcp_pkg::QUARTER_LAST)
			begin
				next_cur.div = cur.div + 8'h01;
				next_cur.scl = cur.scl;
			end
			else
			begin
				next_cur.div = 8'h00;
				if (cur.scl)
					next_cur.scl = 1'b0;
				else
					next_cur.scl = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		cur <= next_cur;
	end

	assign rdata_out = cur.rdata;
	assign busy_out = (cur.st != sbcp_pkg::H_IDLE);
	assign link.scl = cur.scl;
	assign link.host_sda_oe = cur.oe;
	assign link.host_sda_o = 1'b0;
endmodule : sbcp_host

`default_nettype wire

/* verification/sbcp_link_chk.sv */
// link checker: acknowledge slots, drive ownership and idle after stop
// assumes scl is made by the host from clk_in, so one domain is enough
`timescale 1ns/1ps
`default_nettype none

module sbcp_link_chk (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic scl_q;
	logic sda_q;
	logic rd_frame;
	logic [3:0] bit_n;
	logic [3:0] byte_n;
	logic [7:0] shreg;
	logic rise;
	logic start_ev;

	////////////////////////////////////////////////////////////////////////
	// edge and frame tracking; bit_n 8 marks the acknowledge slot
	assign rise = scl & ~scl_q;
	assign start_ev = scl & scl_q & sda_q & ~sda;

	// counters restart at every start, repeated ones included
	always_ff @(posedge clk_in)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (reset_in || start_ev)
		begin
			bit_n <= 4'h0;
			byte_n <= 4'h0;
			rd_frame <= 1'b0;
		end
		else if (rise)
		begin
			bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
			if (bit_n == 4'h8 && byte_n != 4'hf)
				byte_n <= byte_n + 4'h1;
			if (bit_n == 4'h8 && byte_n == 4'h0)
				rd_frame <= shreg[0];
			if (bit_n < 4'h8)
				shreg <= {shreg[6:0], sda};
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	addr_ack_a: assert property (rise && bit_n == 4'h8 && byte_n == 4'h0
		&& (shreg == sbcp_pkg::ADDR_WR || shreg == sbcp_pkg::ADDR_RD)
		|-> !sda) else $error("address byte not acknowledged");
	index_ack_a: assert property (rise && bit_n == 4'h8 && byte_n == 4'h1
		&& !rd_frame |-> !sda) else $error("index byte not acknowledged");
	count_ack_a: assert property (rise && bit_n == 4'h8 && byte_n == 4'h2
		&& !rd_frame |-> !sda) else $error("count byte not acknowledged");
	data_ack_a: assert property (rise && bit_n == 4'h8 && byte_n >= 4'h3
		&& !rd_frame |-> !sda) else $error("write data not acknowledged");
	host_release_a: assert property (rise && bit_n == 4'h8
		&& (byte_n == 4'h0 || !rd_frame) |-> !host_sda_oe)
		else $error("host drives in device acknowledge slot");
	dev_quiet_a: assert property (rise && bit_n < 4'h8
		&& (byte_n == 4'h0 || !rd_frame) |-> !dev_sda_oe)
		else $error("device drives while host sends");
	read_ack_gap_a: assert property (rise && bit_n == 4'h8
		&& byte_n >= 4'h1 && rd_frame |-> !dev_sda_oe)
		else $error("device drives in host acknowledge slot");
	data_hold_a: assert property (rise |-> $stable(sda) [*8])
		else $error("data changed right after clock rise");
	bus_idle_a: assert property (scl && scl_q && !sda_q && sda
		|-> sda [*8]) else $error("data line not idle after stop");

	read_seen_c: cover property (rise && bit_n == 4'h8 && rd_frame
		&& byte_n == 4'h2);
endmodule : sbcp_link_chk

`default_nettype wire

/* verification/testbench.sv */
// bench: host and device joined over the link, driven by the plain port
// assumes the host makes scl; reset spans several scl falls
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int TIMEOUT = 90000;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rdata_out;
	logic busy_out;
	logic pd_s, halt_s, pd_l, bw_s, zdb_s, halve_s;
	logic [7:0] read_count_out;
	logic [7:0] rx;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;

	sbcp_link_if link ();
	sbcp_host u_sbcp_host (.clk_in(clk_in), .reset_in(reset_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .busy_out(busy_out), .link(link));
	sbcp_device u_sbcp_device (.link(link), .reset_in(reset_in),
		.powerdown_output_style_out(pd_s), .clock_halt_output_style_out(halt_s),
		.powerdown_pin_level_select_out(pd_l),
		.loop_bandwidth_select_out(bw_s), .zero_delay_operation_out(zdb_s),
		.input_halving_select_out(halve_s), .read_count_out(read_count_out));
	sbcp_link_chk u_sbcp_link_chk (.clk_in(clk_in), .reset_in(reset_in),
		.scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe));

	// 20 MHz clock
	always #(sbcp_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// one-cycle strobes; a gap cycle keeps drivers from double assigning
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask : bus_read

	// start a transfer and poll busy under a bound
	task automatic xfer(input logic [7:0] n, input logic [7:0] x,
		input int cmd_bit);
		int k;
		k = 0;
		bus_write(sbcp_pkg::HOST_INDEX, n);
		bus_write(sbcp_pkg::HOST_COUNT, x);
		bus_write(sbcp_pkg::HOST_CMD, 8'(1 << cmd_bit));
		repeat (3) @(posedge clk_in);
		#1;
		chk("busy", 8'h01, {7'h00, busy_out}); // transfer running
		while (busy_out !== 1'b0 && k < 20000)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		bus_read(sbcp_pkg::HOST_STATUS, rx);
		chk("status", 8'h00, rx); // no error flag
	endtask : xfer

	// reserved bits 4 and 3 have no outputs, so they are masked
	task automatic check_mode(input logic [7:0] exp);
		logic [7:0] got;
		got = {pd_s, halt_s, pd_l, 2'b00, bw_s, zdb_s, halve_s};
		chk("mode byte", exp & 8'he7, got);
	endtask : check_mode

	task automatic check_rx(input logic [7:0] cnt, input logic [7:0] e [$]);
		bus_read(sbcp_pkg::HOST_RXCNT, rx);
		chk("count byte", cnt, rx); // sent first
		foreach (e[i])
		begin
			bus_read(sbcp_pkg::HOST_BUF + 4'(i), rx);
			chk("read byte", e[i], rx); // bytes from N on
		end
	endtask : check_rx

	////////////////////////////////////////////////////////////////////////
	// hang guard
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// long reset: the device only resets on a falling scl edge
	initial
	begin
		repeat (300) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		check_mode(sbcp_pkg::MODE_RESET);
		chk("count reg", sbcp_pkg::COUNT_RESET, read_count_out);
		bus_read(4'h5, rx);
		chk("unmapped", 8'h00, rx); // empty slot reads zero
		bus_write(sbcp_pkg::HOST_CMD, 8'h00);
		repeat (4) @(posedge clk_in);
		#1;
		chk("busy", 8'h00, {7'h00, busy_out}); // empty command ignored
		$display("test reset done");
		bus_write(sbcp_pkg::HOST_BUF, 8'he0);
		bus_write(sbcp_pkg::HOST_BUF + 4'h1, 8'h5a);
		xfer(8'h00, 8'h02, sbcp_pkg::CMD_WRITE_BIT);
		check_mode(8'he0);
		$display("test mode write done");
		bus_write(sbcp_pkg::HOST_BUF, 8'h3c);
		bus_write(sbcp_pkg::HOST_BUF + 4'h1, 8'h03);
		xfer(8'h05, 8'h02, sbcp_pkg::CMD_WRITE_BIT);
		chk("count reg", 8'h03, read_count_out);
		check_mode(8'he0); // byte 0 untouched
		$display("test count write done");
		xfer(8'h00, 8'h03, sbcp_pkg::CMD_READ_BIT);
		check_rx(8'h03, '{8'he0, 8'h5a, 8'h00});
		xfer(8'h05, 8'h02, sbcp_pkg::CMD_READ_BIT);
		check_rx(8'h03, '{8'h3c, 8'h03});
		$display("test block read done");
		bus_write(sbcp_pkg::HOST_BUF, 8'h07);
		xfer(8'h06, 8'h01, sbcp_pkg::CMD_WRITE_BIT);
		chk("count reg", 8'h07, read_count_out);
		$display("test count restore done");
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
